// [shared/vmfd_map.vh]
// Constants for the vector memory field decoder: bus map, field layout,
// opcode and width codes, and reset values.
// Assumes inclusion by bare name from verilog/ design files.
`ifndef VMFD_MAP_VH
`define VMFD_MAP_VH

// Register byte offsets, one aligned word each
`define VMFD_OFF_INSN 12'h000
`define VMFD_OFF_VCFG 12'h004
`define VMFD_OFF_DEC0 12'h008
`define VMFD_OFF_DEC1 12'h00c
`define VMFD_OFF_BASE 12'h010
`define VMFD_OFF_STRD 12'h014

// Instruction field positions
`define VMFD_OPC_HI 6
`define VMFD_OPC_LO 0
`define VMFD_VREG_HI 11
`define VMFD_VREG_LO 7
`define VMFD_WID_HI 14
`define VMFD_WID_LO 12
`define VMFD_BASE_HI 19
`define VMFD_BASE_LO 15
`define VMFD_RS2_HI 24
`define VMFD_RS2_LO 20
`define VMFD_VM_BIT 25
`define VMFD_MOP_HI 27
`define VMFD_MOP_LO 26
`define VMFD_MEW_BIT 28
`define VMFD_NF_HI 31
`define VMFD_NF_LO 29

// Major opcodes shared with scalar FP loads and stores
`define VMFD_OPC_LOAD_FP 7'h07
`define VMFD_OPC_STORE_FP 7'h27

// Vector width codes, named by element size in bits
`define VMFD_WID_E8 3'h0
`define VMFD_WID_E16 3'h5
`define VMFD_WID_E32 3'h6
`define VMFD_WID_E64 3'h7

// Addressing mode codes
`define VMFD_MOP_UNIT 2'h0
`define VMFD_MOP_IDX_UNORD 2'h1
`define VMFD_MOP_STRIDED 2'h2
`define VMFD_MOP_IDX_ORD 2'h3

// Configuration register fields and reset values
`define VMFD_VCFG_SEW_HI 2
`define VMFD_VCFG_SEW_LO 0
`define VMFD_VCFG_REG_GROUP_MULTIPLIER_HI 6
`define VMFD_VCFG_REG_GROUP_MULTIPLIER_LO 4
`define VMFD_RST_INSN 32'h00000000
`define VMFD_RST_VCFG 32'h00000000

// Group multiplier log2 legal range
`define VMFD_EMUL_MIN -3
`define VMFD_EMUL_MAX 3

`endif

// [verilog/vmfd_field_extract.v]
// Combinational classifier of one vector memory instruction word.
// Assumes the caller registers all outputs; no state here.
`timescale 1ns/1ps
`default_nettype none
`include "vmfd_map.vh"

module vmfd_field_extract
(
  input wire [31:0] insn,
  output reg is_load,
  output reg is_store,
  output reg is_vector,
  output reg width_bad,
  output reg [1:0] eew_log,
  output reg [1:0] mode,
  output reg masked,
  output reg [2:0] seg_count,
  output reg [4:0] umop
)
;
  // Opcode, width field and extension bit picked apart
  wire [6:0] opc = insn[`VMFD_OPC_HI:`VMFD_OPC_LO];
  wire [2:0] wid = insn[`VMFD_WID_HI:`VMFD_WID_LO];
  wire mew = insn[`VMFD_MEW_BIT];

  // Classify opcode, width and mode
  always @*
  begin
    is_load = (opc == `VMFD_OPC_LOAD_FP);
    is_store = (opc == `VMFD_OPC_STORE_FP);
    mode = insn[`VMFD_MOP_HI:`VMFD_MOP_LO];
    masked = ~insn[`VMFD_VM_BIT];
    seg_count = insn[`VMFD_NF_HI:`VMFD_NF_LO];
    umop = insn[`VMFD_RS2_HI:`VMFD_RS2_LO];
    is_vector = 1'b1;
    eew_log = 2'h0;
    // Width codes not taken by scalar FP mean vector
    case (wid)
      `VMFD_WID_E8: eew_log = 2'h0;
      `VMFD_WID_E16: eew_log = 2'h1;
      `VMFD_WID_E32: eew_log = 2'h2;
      `VMFD_WID_E64: eew_log = 2'h3;
      default: is_vector = 1'b0;
    endcase
    // Extended width bit set names widths above 64, none supported
    width_bad = mew;
  end

endmodule // vmfd_field_extract
`default_nettype wire

// [verilog/vmfd_top.v]
// Vector memory instruction field decoder with an AHB-Lite register slave.
// Assumes a single zero-wait slave position and a combinational
// scalar register file read port answering in the same cycle.
//
// Operation
// - Indexed stores take data vreg from bits 11:7
// - Width field sizes elements, splits from scalar FP
// - Extension bit set flags the instruction illegal
// - Mode field picks the addressing mode
// - Field count gives fields per segment
// - Unit and strided data width from instruction
// - Indexed: instruction width sizes index elements
// - Indexed data width, grouping from configuration
// - Masking control taken from bit 25
// - Base address read from named scalar register
// - Modes: unit, indexed-unordered, strided, indexed-ordered
//
// The AHB-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "vmfd_map.vh"

module vmfd_top
#(
  parameter XLEN = 32
)
(
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  output reg [4:0] base_addr_xreg_sel,
  output reg [4:0] stride_xreg_sel,
  input wire [XLEN-1:0] base_xreg_data,
  input wire [XLEN-1:0] stride_xreg_data,
  output reg exu_valid,
  output reg exu_is_load,
  output reg exu_is_store,
  output reg exu_illegal,
  output reg [1:0] exu_mode,
  output reg exu_masked,
  output reg [2:0] exu_seg_count,
  output reg [4:0] exu_data_vreg_sel,
  output reg [4:0] exu_offset_vreg_sel,
  output reg [1:0] exu_data_width,
  output reg [1:0] exu_index_width,
  output reg [2:0] exu_group_mult,
  output reg [XLEN-1:0] exu_base_addr,
  output reg [XLEN-1:0] exu_stride
)
;
  // Software state
  reg [31:0] insn; // Instruction under decode
  reg [2:0] configured_elem_width; // log2 bytes of CONFIGURED_ELEM_WIDTH
  reg [2:0] reg_group_multiplier; // Signed log2 of REG_GROUP_MULTIPLIER
  // Bus data-phase bookkeeping
  reg dp_write; // Write data phase pending
  reg [11:0] dp_addr; // Address held for the data phase
  reg start; // Pulse: new instruction written
  reg stage2; // Pulse: fields latched, fetch scalars
  // Decoded fields kept for readback
  reg [4:0] dec_umop;
  reg dec_indexed;

  // Classifier outputs
  wire c_load;
  wire c_store;
  wire c_vec;
  wire c_wbad;
  wire [1:0] c_eew;
  wire [1:0] c_mode;
  wire c_masked;
  wire [2:0] c_nf;
  wire [4:0] c_umop;

  vmfd_field_extract u_extract
  (
    .insn(insn),
    .is_load(c_load),
    .is_store(c_store),
    .is_vector(c_vec),
    .width_bad(c_wbad),
    .eew_log(c_eew),
    .mode(c_mode),
    .masked(c_masked),
    .seg_count(c_nf),
    .umop(c_umop)
  );

  // Mode groups
  wire c_indexed = c_mode[0];
  wire c_strided = (c_mode == `VMFD_MOP_STRIDED);

  // Effective group multiplier for instruction-sized data
  wire signed [4:0] emul_calc = $signed({3'b000, c_eew})
    - $signed({2'b00, configured_elem_width})
    + $signed({{2{reg_group_multiplier[2]}}, reg_group_multiplier});
  wire emul_bad = (emul_calc < `VMFD_EMUL_MIN) || (emul_calc > `VMFD_EMUL_MAX);

  // Data width and grouping source depends on addressing mode
  reg [1:0] next_data_width;
  reg [2:0] next_group;
  reg next_illegal;
  always @*
  begin
    if (c_indexed)
    begin
      // Indexed: data follows the configuration
      next_data_width = configured_elem_width[1:0];
      next_group = reg_group_multiplier;
    end
    else
    begin
      // Unit and strided: data width fixed by the encoding
      next_data_width = c_eew;
      next_group = emul_calc[2:0];
    end
    // Reserved width or grouping, or not a vector op at all
    next_illegal = ~(c_load | c_store) | ~c_vec | c_wbad
      | (emul_bad & ~c_indexed) | configured_elem_width[2];
  end

  // AHB address phase qualifier
  wire ap_take = hsel & hready & htrans[1];

  // Read mux, registered at the address-phase edge
  reg [31:0] next_rdata;
  always @*
  begin
    next_rdata = 32'h00000000;
    case (haddr)
      `VMFD_OFF_INSN: next_rdata = insn;
      `VMFD_OFF_VCFG: next_rdata = {25'h0000000, reg_group_multiplier,
        1'b0, configured_elem_width};
      `VMFD_OFF_DEC0: next_rdata = {3'h0, exu_illegal, exu_is_store, exu_is_load,
        exu_masked, exu_mode, exu_seg_count, exu_data_vreg_sel,
        exu_offset_vreg_sel, stride_xreg_sel, base_addr_xreg_sel};
      `VMFD_OFF_DEC1: next_rdata = {19'h00000, dec_umop, dec_indexed,
        exu_group_mult, exu_index_width, exu_data_width};
      `VMFD_OFF_BASE: next_rdata = exu_base_addr[31:0];
      `VMFD_OFF_STRD: next_rdata = exu_stride[31:0];
      default: next_rdata = 32'h00000000; // Unmapped reads as zero
    endcase
  end

  // Bus slave: zero wait, always OKAY
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      dp_write <= 1'b0;
      dp_addr <= 12'h000;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hready)
      begin
        dp_write <= ap_take & hwrite;
        dp_addr <= haddr;
        // Reads sampled now, so a read right after a write sees old data
        if (ap_take & ~hwrite)
          hrdata <= next_rdata;
      end
    end
  end

  // Software registers, written in the data phase
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      insn <= `VMFD_RST_INSN;
      configured_elem_width <= 3'h0;
      reg_group_multiplier <= 3'h0;
      start <= 1'b0;
    end
    else
    begin
      start <= 1'b0;
      if (dp_write)
      begin
        if (dp_addr == `VMFD_OFF_INSN)
        begin
          insn <= hwdata;
          start <= 1'b1;
        end
        else if (dp_addr == `VMFD_OFF_VCFG)
        begin
          configured_elem_width <= hwdata[`VMFD_VCFG_SEW_HI:`VMFD_VCFG_SEW_LO];
          reg_group_multiplier <= hwdata[`VMFD_VCFG_REG_GROUP_MULTIPLIER_HI:`VMFD_VCFG_REG_GROUP_MULTIPLIER_LO];
        end
      end
    end
  end

  // Stage one: latch decoded fields and drive scalar selects
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      stage2 <= 1'b0;
      base_addr_xreg_sel <= 5'h00;
      stride_xreg_sel <= 5'h00;
      exu_is_load <= 1'b0;
      exu_is_store <= 1'b0;
      exu_illegal <= 1'b0;
      exu_mode <= 2'h0;
      exu_masked <= 1'b0;
      exu_seg_count <= 3'h0;
      exu_data_vreg_sel <= 5'h00;
      exu_offset_vreg_sel <= 5'h00;
      exu_data_width <= 2'h0;
      exu_index_width <= 2'h0;
      exu_group_mult <= 3'h0;
      dec_umop <= 5'h00;
      dec_indexed <= 1'b0;
    end
    else
    begin
      stage2 <= start;
      if (start)
      begin
        base_addr_xreg_sel <= insn[`VMFD_BASE_HI:`VMFD_BASE_LO];
        // Stride specifier only for strided mode
        stride_xreg_sel <= c_strided ? insn[`VMFD_RS2_HI:`VMFD_RS2_LO] : 5'h00;
        // Offset vreg only for indexed modes
        exu_offset_vreg_sel <= c_indexed ? insn[`VMFD_RS2_HI:`VMFD_RS2_LO] : 5'h00;
        // Bits 11:7 are store data on stores, destination on loads
        exu_data_vreg_sel <= insn[`VMFD_VREG_HI:`VMFD_VREG_LO];
        exu_is_load <= c_load;
        exu_is_store <= c_store;
        exu_illegal <= next_illegal;
        exu_mode <= c_mode;
        exu_masked <= c_masked;
        exu_seg_count <= c_nf;
        exu_data_width <= next_data_width;
        // Index width from the encoding, zero when not indexed
        exu_index_width <= c_indexed ? c_eew : 2'h0;
        exu_group_mult <= next_group;
        dec_umop <= (c_mode == `VMFD_MOP_UNIT) ? c_umop : 5'h00;
        dec_indexed <= c_indexed;
      end
    end
  end

  // Stage two: capture scalar operands and signal the execution unit
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      exu_valid <= 1'b0;
      exu_base_addr <= {XLEN{1'b0}};
      exu_stride <= {XLEN{1'b0}};
    end
    else
    begin
      exu_valid <= stage2;
      if (stage2)
      begin
        exu_base_addr <= base_xreg_data;
        // Stride value meaningless outside strided mode
        exu_stride <= (exu_mode == `VMFD_MOP_STRIDED) ? stride_xreg_data
          : {XLEN{1'b0}};
      end
    end
  end

endmodule // vmfd_top
`default_nettype wire

// [verif/vmfd_xreg_model.sv]
// Scalar register file model answering the decoder's base and stride reads.
// Assumes combinational same-cycle reads; the bench fills the contents.
`timescale 1ns/1ps
`default_nettype none

module vmfd_xreg_model
(
  input wire logic [4:0] base_sel,
  input wire logic [4:0] stride_sel,
  output logic [31:0] base_data,
  output logic [31:0] stride_data
);
  // Register contents, entry zero kept at zero by the bench
  logic [31:0] regs [32];
  // Read ports follow the selects at once, as the decoder expects
  assign base_data = regs[base_sel];
  assign stride_data = regs[stride_sel];
endmodule // vmfd_xreg_model

`default_nettype wire

// [verif/vmfd_top_checker.sv]
// Port assertions for the vector memory field decoder.
// Assumes the zero-wait slave and the three-edge decode after INSN data.
`timescale 1ns/1ps
`default_nettype none

module vmfd_top_checker
#(
  parameter XLEN = 32
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic [XLEN-1:0] base_xreg_data,
  input wire logic [XLEN-1:0] stride_xreg_data,
  input wire logic [4:0] stride_xreg_sel,
  input wire logic exu_valid,
  input wire logic [1:0] exu_mode,
  input wire logic exu_masked,
  input wire logic [2:0] exu_seg_count,
  input wire logic [4:0] exu_data_vreg_sel,
  input wire logic [4:0] exu_offset_vreg_sel,
  input wire logic [XLEN-1:0] exu_base_addr,
  input wire logic [XLEN-1:0] exu_stride
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Address phase of an INSN write, ending on its data edge
  sequence s_insn_wr;
    hsel && hready && htrans[1] && hwrite && haddr == 12'h000 ##1 1'b1;
  endsequence
  // Result pulse three edges after the data edge
  sequence s_done;
    ##3 exu_valid;
  endsequence
  AST_MODE: assert property (s_insn_wr |-> s_done ##0
    exu_mode == $past(hwdata[27:26], 3)) else $error("mode field misrouted");
  AST_MASK: assert property (s_insn_wr |-> s_done ##0
    exu_masked == !$past(hwdata[25], 3)) else $error("mask flag wrong");
  AST_SEG: assert property (s_insn_wr |-> s_done ##0
    exu_seg_count == $past(hwdata[31:29], 3)) else $error("segment count wrong");
  AST_DVREG: assert property (s_insn_wr |-> s_done ##0
    exu_data_vreg_sel == $past(hwdata[11:7], 3)) else $error("data vector register wrong");
  AST_OFFSET: assert property (s_insn_wr |-> s_done ##0 exu_offset_vreg_sel ==
    ($past(hwdata[26], 3) ? $past(hwdata[24:20], 3) : 5'h00)) else $error("offset select wrong");
  AST_PULSE: assert property (exu_valid |=> !exu_valid)
    else $error("valid longer than one cycle");
  AST_BASE: assert property ($rose(exu_valid) |-> exu_base_addr == $past(base_xreg_data))
    else $error("base address not captured");
  AST_STRIDE: assert property ($rose(exu_valid) |-> exu_stride ==
    (exu_mode == 2'h2 ? $past(stride_xreg_data) : {XLEN{1'b0}})) else $error("stride wrong");
  AST_SSEL: assert property (exu_valid && exu_mode != 2'h2 |-> stride_xreg_sel == 5'h00)
    else $error("stride select used outside strided");
endmodule // vmfd_top_checker

bind vmfd_top vmfd_top_checker #(.XLEN(XLEN)) u_vmfd_top_checker (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hwdata(hwdata), .base_xreg_data(base_xreg_data),
  .stride_xreg_data(stride_xreg_data), .stride_xreg_sel(stride_xreg_sel),
  .exu_valid(exu_valid), .exu_mode(exu_mode), .exu_masked(exu_masked),
  .exu_seg_count(exu_seg_count), .exu_data_vreg_sel(exu_data_vreg_sel),
  .exu_offset_vreg_sel(exu_offset_vreg_sel), .exu_base_addr(exu_base_addr),
  .exu_stride(exu_stride));

`default_nettype wire

// [verif/vmfd_top_tb.sv]
// Self-checking bench: random vector memory instructions with corner cases.
// Assumes the register file model and the zero-wait AHB-Lite slave.
`timescale 1ns/1ps
`default_nettype none
`include "vmfd_map.vh"

module vmfd_top_tb;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic [11:0] haddr = 0;
  logic [1:0] htrans = 0;
  logic [31:0] hwdata = 0, hrdata, rd, ins;
  logic [6:0] cfg; // Group multiplier and element width setting
  logic hreadyout, hresp, exu_valid, exu_is_load, exu_is_store, exu_illegal, exu_masked;
  logic [4:0] bsel, ssel, exu_data_vreg_sel, exu_offset_vreg_sel;
  logic [31:0] bdat, sdat, exu_base_addr, exu_stride;
  logic [1:0] exu_mode, exu_data_width, exu_index_width;
  logic [2:0] exu_seg_count, exu_group_mult;
  int num_errors = 0, tests_run = 0, seed = 32'h8e4ad9c8;

  // Free running 10 MHz clock
  always #50 hclk = ~hclk;

  vmfd_top u_vmfd_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .base_addr_xreg_sel(bsel),
    .stride_xreg_sel(ssel), .base_xreg_data(bdat), .stride_xreg_data(sdat),
    .exu_valid(exu_valid), .exu_is_load(exu_is_load), .exu_is_store(exu_is_store),
    .exu_illegal(exu_illegal), .exu_mode(exu_mode), .exu_masked(exu_masked),
    .exu_seg_count(exu_seg_count), .exu_data_vreg_sel(exu_data_vreg_sel),
    .exu_offset_vreg_sel(exu_offset_vreg_sel), .exu_data_width(exu_data_width),
    .exu_index_width(exu_index_width), .exu_group_mult(exu_group_mult),
    .exu_base_addr(exu_base_addr), .exu_stride(exu_stride));

  vmfd_xreg_model u_vmfd_xreg_model (.base_sel(bsel), .stride_sel(ssel), .base_data(bdat),
    .stride_data(sdat));

  // Verdict and end of run
  task automatic conclude();
    if (num_errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Compare and count
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One single AHB-Lite transfer; waits on hready in both phases
  // No cycle limit here: only the watchdog ends a hung wait
  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d,
    output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
    // Slave must stay ready and answer OKAY
    check("bus response", {hreadyout, hresp}, 32'h2);
  endtask

  // Decode one instruction under one configuration and judge the result
  task automatic run_one(input logic [31:0] i, input logic [6:0] c);
    logic [1:0] m, eew;
    logic [2:0] grp;
    logic ix, bad;
    logic [31:0] d0; // Expected DEC0 word
    int n, emul;
    m = i[27:26];
    ix = m[0];
    eew = i[13:12];
    emul = int'(eew) - int'(c[2:0]) + int'($signed(c[6:4]));
    grp = ix ? c[6:4] : 3'(emul);
    bad = (i[6:0] != 7'h07 && i[6:0] != 7'h27) || (i[14:12] inside {[3'h1:3'h4]}) || i[28]
      || c[2] || (!ix && (emul < -3 || emul > 3));
    bus(`VMFD_OFF_VCFG, 1'b1, {25'h0, c}, rd);
    bus(`VMFD_OFF_INSN, 1'b1, i, rd);
    n = 0;
    while (exu_valid !== 1'b1 && n++ < 20) @(posedge hclk);
    check("valid", exu_valid, 1);
    check("illegal", exu_illegal, bad);
    check("kind", {exu_is_load, exu_is_store}, {i[6:0] == 7'h07, i[6:0] == 7'h27});
    check("stride sel", ssel, m == 2'h2 ? i[24:20] : 5'h0);
    check("base sel", bsel, i[19:15]);
    check("base", exu_base_addr, u_vmfd_xreg_model.regs[i[19:15]]);
    check("stride", exu_stride, m == 2'h2 ? u_vmfd_xreg_model.regs[i[24:20]] : 32'h0);
    // Readback of the decoded fields and captured operands
    bus(`VMFD_OFF_DEC0, 1'b0, 32'h0, rd);
    d0 = {3'h0, bad, i[6:0] == 7'h27, i[6:0] == 7'h07, ~i[25], m, i[31:29], i[11:7],
      ix ? i[24:20] : 5'h0, m == 2'h2 ? i[24:20] : 5'h0, i[19:15]};
    check("dec0", rd, d0);
    bus(`VMFD_OFF_BASE, 1'b0, 32'h0, rd);
    check("base readback", rd, u_vmfd_xreg_model.regs[i[19:15]]);
    bus(`VMFD_OFF_STRD, 1'b0, 32'h0, rd);
    check("stride readback", rd, m == 2'h2 ? u_vmfd_xreg_model.regs[i[24:20]] : 32'h0);
    if (!bad)
    begin
      check("data width", exu_data_width, ix ? c[1:0] : eew);
      check("index width", exu_index_width, ix ? eew : 2'h0);
      check("group", exu_group_mult, grp);
      bus(`VMFD_OFF_DEC1, 1'b0, 32'h0, rd);
      check("dec1", rd[12:0], {m == 2'h0 ? i[24:20] : 5'h0, ix, grp, ix ? eew : 2'h0,
        ix ? c[1:0] : eew});
    end
  endtask

  // Main sequence: reset, register corners, then random decodes
  initial
  begin
    for (int k = 0; k < 32; k++) u_vmfd_xreg_model.regs[k] = (k == 0) ? 32'h0 : $random(seed);
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(`VMFD_OFF_VCFG, 1'b0, 32'h0, rd);
    check("vcfg reset", rd, `VMFD_RST_VCFG);
    bus(12'h030, 1'b1, 32'hffffffff, rd);
    bus(12'h030, 1'b0, 32'h0, rd);
    check("unmapped", rd, 32'h0);
    for (int k = 0; k < 48; k++)
    begin
      ins = $random(seed);
      // Every opcode and mode in turn; scalar width, extension bit, foreign opcode as corners
      ins[6:0] = (k == 5) ? 7'h33 : (k[0] ? `VMFD_OPC_STORE_FP : `VMFD_OPC_LOAD_FP);
      ins[14:12] = (k % 8 == 7) ? 3'h2 : (ins[13:12] == 2'h0 ? 3'h0 : {1'b1, ins[13:12]});
      ins[28] = (k == 13);
      ins[27:26] = k[2:1];
      cfg = 7'($random(seed));
      cfg[3] = 1'b0;
      cfg[2] = (k == 21);
      run_one(ins, cfg);
    end
    bus(`VMFD_OFF_INSN, 1'b0, 32'h0, rd);
    check("insn readback", rd, ins);
    conclude();
  end

  // Watchdog against a hung handshake
  initial
  begin
    #500000;
    num_errors++;
    conclude();
  end
endmodule // vmfd_top_tb

`default_nettype wire
